//--- hdl/occs_clock_select.sv
// oscillator mode decode, pin muxing, internal block select, trim register
//
// What this block does
// - mode taken from config field after reset
// - pll mode multiplies crystal by four
// - pll enabled only in pll mode
// - high-speed mode also accepts external clock
// - external clock modes skip start-up delay
// - external clock mode outputs fosc/4
// - external io mode frees out pin as bit6
// - rc mode outputs fosc/4 on out pin
// - rc io mode frees out pin as bit6
// - fast source 8 MHz, postscaled 125k-4M
// - fast source on for 125k-8M selections
// - slow source on for internal or features
// - freq select picks direct or postscaled source
// - select codes 111 fast, 000 slow
// - clkout mode: fosc/4 out, in pin bit7
// - dual io mode: both pins general io
// - slow settles eight cycles, fast 1 ms
// - no status for trim shift done
// - trim bits 7:6 read zero, reset zero
// - trim is signed step, zero is centre
`timescale 1ns/10ps
`include "occs_defines.svh"
module occs_clock_select
    import occs_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // non-volatile mode field
    input  wire logic [3:0]  osc_mode_config,
    // oscillator cycle pulses
    input  wire logic        primary_osc_tick,
    input  wire logic        fast_osc_tick,
    input  wire logic        slow_osc_tick,
    // oscillator controls
    output logic             pll_enable,
    output logic             osc_amp_enable,
    output logic             startup_timer_enable,
    output logic             fast_osc_enable,
    output logic             slow_osc_enable,
    output logic signed [5:0] osc_trim_value,
    output occs_src_t        sys_clk_src,
    output logic             sys_osc_tick,
    // primary_osc_in_pin
    input  wire logic        osc_in_pin_in,
    output logic             osc_in_pin_out,
    output logic             osc_in_pin_oe,
    // primary_osc_out_pin
    input  wire logic        osc_out_pin_in,
    output logic             osc_out_pin_out,
    output logic             osc_out_pin_oe,
    // general_io_port_a bits 6 and 7
    input  wire logic        port_a_bit6_out,
    input  wire logic        port_a_bit6_oe,
    output logic             port_a_bit6_in,
    input  wire logic        port_a_bit7_out,
    input  wire logic        port_a_bit7_oe,
    output logic             port_a_bit7_in
);
    // latched mode and load flag
    occs_mode_t  mode_q;
    logic        loaded_q;
    // software registers
    logic [5:0]  trim_q;      // trim_value
    logic [2:0]  fsel_q;      // internal_freq_select
    logic [3:0]  feat_q;      // pwrt, fscm, wdt, two-speed enables
    // registered outputs
    logic        pll_q;
    logic        ost_q;
    logic        fast_q;
    logic        slow_q;
    logic        amp_q;
    // derived decode
    logic        crystal_m;
    logic        ext_m;
    logic        rc_m;
    logic        int_m;
    logic        clkout_m;   // out pin carries fosc/4
    logic        gpio6_m;    // out pin is port bit 6
    logic        gpio7_m;    // in pin is port bit 7
    logic        post_tick;
    logic        int_tick;
    logic        clk_div4;
    occs_mode_t  cfg_mode;
    // apb decode
    logic        wr_en;
    logic        rd_en;
    logic        hit_trim;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_any;
    logic [31:0] rd_data;

    // unused codes 10..15 fall back to code 0, as an erased field would
    // rather than leave the chip with no clock at all
    assign cfg_mode = (osc_mode_config > 4'h9) ? low_power_crystal_mode
                    : occs_mode_t'(osc_mode_config);

    // strap pins may move later; only a reset takes them again
    // mode caught once, first edge after reset release; never again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q   <= low_power_crystal_mode;
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            mode_q   <= cfg_mode;
            loaded_q <= 1'b1;
        end
    end

    // mode families
    assign crystal_m = (mode_q == low_power_crystal_mode)
                    || (mode_q == std_crystal_mode)
                    || (mode_q == high_speed_crystal_mode)
                    || (mode_q == high_speed_pll_mode);
    assign ext_m     = (mode_q == external_clock_mode)
                    || (mode_q == external_clock_io_mode);
    assign rc_m      = (mode_q == resistor_cap_osc_mode)
                    || (mode_q == resistor_cap_io_mode);
    assign int_m     = (mode_q == internal_osc_clkout_mode)
                    || (mode_q == internal_osc_dual_io_mode);

    // pin roles per mode
    // crystal modes give both pins to the amplifier
    // the in pin stays an input outside internal modes
    assign clkout_m = (mode_q == external_clock_mode)
                   || (mode_q == resistor_cap_osc_mode)
                   || (mode_q == internal_osc_clkout_mode);
    assign gpio6_m  = (mode_q == external_clock_io_mode)
                   || (mode_q == resistor_cap_io_mode)
                   || (mode_q == internal_osc_dual_io_mode);
    assign gpio7_m  = int_m;

    // internal source choice from the select code
    // outside internal modes the primary pulse is the clock
    assign sys_clk_src = !int_m ? src_primary
        : (fsel_q == `OCCS_FSEL_FAST) ? src_fast_direct
        : (fsel_q == `OCCS_FSEL_SLOW) ? src_slow_direct
        : src_fast_post;

    // postscaler on the 8 MHz source
    // runs in every mode; its pulse is only used internally
    occs_postscale u_post (
        .pclk     (pclk),
        .presetn  (presetn),
        .src_tick (fast_osc_tick),
        .fsel     (fsel_q),
        .out_tick (post_tick)
    );

    // internal block output; a select change takes effect at once
    // no glitch guard: a select write may cut one period short
    assign int_tick = (sys_clk_src == src_fast_direct) ? fast_osc_tick
                    : (sys_clk_src == src_slow_direct) ? slow_osc_tick
                    : post_tick;

    // system oscillator pulse; in pll mode the pll output arrives here
    assign sys_osc_tick = int_m ? int_tick : primary_osc_tick;

    // fosc/4 on the out pin
    // counts whichever pulse is the system clock
    occs_div4 u_div4 (
        .pclk     (pclk),
        .presetn  (presetn),
        .osc_tick (sys_osc_tick),
        .clk_div4 (clk_div4)
    );

    // oscillator enables, registered for glitch-free control lines
    // all stay low until the mode has been latched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_q  <= 1'b0;
            ost_q  <= 1'b0;
            fast_q <= 1'b0;
            slow_q <= 1'b0;
            amp_q  <= 1'b0;
        end else begin
            pll_q  <= loaded_q && (mode_q == high_speed_pll_mode);
            ost_q  <= loaded_q && crystal_m;
            fast_q <= loaded_q && int_m
                   && (fsel_q != `OCCS_FSEL_SLOW);
            // slow source runs whenever the internal block is the clock
            slow_q <= loaded_q && (int_m || (|feat_q));
            amp_q  <= loaded_q && crystal_m;
        end
    end

    assign pll_enable           = pll_q;
    assign startup_timer_enable = ost_q;
    assign fast_osc_enable      = fast_q;
    assign slow_osc_enable      = slow_q;
    // the amplifier input also takes a driven clock in high-speed mode
    assign osc_amp_enable       = amp_q;

    // the analog side reads trim as a two's-complement step
    // trim goes straight to both oscillators; they drift to the new
    // frequency by themselves while code runs, nothing here waits
    assign osc_trim_value = $signed(trim_q);

    // out pin: fosc/4, port bit 6, or left to the crystal
    // in crystal modes oe stays low so the amplifier owns the pin
    assign osc_out_pin_out = clkout_m ? clk_div4 : port_a_bit6_out;
    assign osc_out_pin_oe  = clkout_m ? 1'b1
                           : (gpio6_m && port_a_bit6_oe);
    // in pin: port bit 7 in internal modes, else never driven
    assign osc_in_pin_out  = gpio7_m && port_a_bit7_out;
    assign osc_in_pin_oe   = gpio7_m && port_a_bit7_oe;
    // port reads see the pin only when the pin is general io
    assign port_a_bit6_in  = gpio6_m && osc_out_pin_in;
    assign port_a_bit7_in  = gpio7_m && osc_in_pin_in;

    // apb decode; every access finishes in its first access cycle
    // the address is matched in full, no aliasing
    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && !pwrite;
    assign hit_trim = (paddr == `OCCS_TRIM_OFS);
    assign hit_ctrl = (paddr == `OCCS_CTRL_OFS);
    assign hit_stat = (paddr == `OCCS_STAT_OFS);
    assign hit_any  = hit_trim || hit_ctrl || hit_stat;
    // no wait states: every register is a plain flop
    assign pready   = 1'b1;
    // writes to status are refused like unmapped addresses
    assign pslverr  = psel && penable
                   && (!hit_any || (hit_stat && pwrite));

    // read mux; reserved bits read zero
    // status shows the latched mode, not the strap pins
    assign rd_data = hit_trim ? {26'h0, trim_q}
        : hit_ctrl ? {24'h0, feat_q, 1'b0, fsel_q}
        : hit_stat ? {24'h0, ost_q, slow_q, fast_q, pll_q, 4'(mode_q)}
        : 32'h0000_0000;

    // software registers; status holds no trim-done flag
    // control bit 3 is not stored and reads zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_q <= `OCCS_TRIM_RST;
            fsel_q <= `OCCS_FSEL_RST;
            feat_q <= 4'h0;
        end else if (wr_en && hit_trim) begin
            trim_q <= pwdata[`OCCS_TRIM_MSB:0];
        end else if (wr_en && hit_ctrl) begin
            fsel_q <= pwdata[`OCCS_FSEL_MSB:0];
            feat_q <= pwdata[`OCCS_TSS_BIT:`OCCS_PWRT_BIT];
        end
    end

    // read data captured in the setup cycle, valid in the access cycle
    // this is what lets the access phase end at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            prdata <= rd_data;
        end
    end

    // checks on this block's own outputs and latched mode
    // all of them sleep while reset is held
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pll_mode_only_a: assert property (
        pll_enable |-> (mode_q == high_speed_pll_mode))
        else $error("pll on outside pll mode");

    pll_on_a: assert property (
        loaded_q && (mode_q == high_speed_pll_mode) |=> pll_enable)
        else $error("pll off in pll mode");

    ext_no_delay_a: assert property (
        ext_m |-> ##1 !startup_timer_enable)
        else $error("start-up delay in external clock mode");

    mode_frozen_a: assert property (
        loaded_q |=> $stable(mode_q))
        else $error("mode changed after load");

    cfg_default_a: assert property (
        !loaded_q && (osc_mode_config > 4'h9)
            |=> (mode_q == low_power_crystal_mode))
        else $error("unused mode code not mapped to code 0");

    hs_amp_on_a: assert property (
        loaded_q && (mode_q == high_speed_crystal_mode) |=> osc_amp_enable)
        else $error("amplifier off in high-speed mode");

    fast_off_a: assert property (
        !int_m |=> !fast_osc_enable)
        else $error("fast source on outside internal modes");

    clkout_pin_a: assert property (
        clkout_m |-> osc_out_pin_oe && (osc_out_pin_out == clk_div4))
        else $error("out pin not carrying fosc/4");

    gpio6_pin_a: assert property (
        gpio6_m |-> (osc_out_pin_oe == port_a_bit6_oe)
            && (port_a_bit6_in == osc_out_pin_in))
        else $error("out pin not port bit 6");

    gpio7_pin_a: assert property (
        !int_m |-> !osc_in_pin_oe && !port_a_bit7_in)
        else $error("in pin used as io outside internal modes");

    fast_en_a: assert property (
        loaded_q && int_m && (fsel_q != `OCCS_FSEL_SLOW)
            && $stable(fsel_q) |=> fast_osc_enable)
        else $error("fast source off while selected");

    slow_en_a: assert property (
        loaded_q && (int_m || (feat_q != 4'h0)) |=> slow_osc_enable)
        else $error("slow source off while needed");

    slow_cause_a: assert property (
        slow_osc_enable |-> int_m || ($past(feat_q) != 4'h0))
        else $error("slow source on without cause");

    trim_read_a: assert property (
        psel && !penable && !pwrite && hit_trim
            |=> prdata[31:6] == 26'h0)
        else $error("trim reserved bits not zero");

    div4_duty_a: assert property (
        !sys_osc_tick |=> $stable(clk_div4))
        else $error("clkout moved without an oscillator pulse");

    src_sel_a: assert property (
        int_m && (fsel_q == `OCCS_FSEL_FAST)
            |-> sys_osc_tick == fast_osc_tick)
        else $error("direct fast source not selected");
endmodule

//--- hdl/occs_defines.svh
// register map, field positions, reset values and pll limits for clock select
`ifndef OCCS_DEFINES_SVH
`define OCCS_DEFINES_SVH
// register byte offsets
`define OCCS_TRIM_OFS      12'h000
`define OCCS_CTRL_OFS      12'h004
`define OCCS_STAT_OFS      12'h008
// trim register fields
`define OCCS_TRIM_MSB      5
`define OCCS_TRIM_RST      6'h00
// control register fields
`define OCCS_FSEL_MSB      2
`define OCCS_FSEL_RST      3'h0
`define OCCS_PWRT_BIT      4
`define OCCS_FSCM_BIT      5
`define OCCS_WDT_BIT       6
`define OCCS_TSS_BIT       7
// status register fields
`define OCCS_ST_PLL_BIT    4
`define OCCS_ST_FAST_BIT   5
`define OCCS_ST_SLOW_BIT   6
`define OCCS_ST_OST_BIT    7
// internal_freq_select codes
`define OCCS_FSEL_SLOW     3'h0
`define OCCS_FSEL_FAST     3'h7
// pll multiplier and limits, kHz
`define OCCS_PLL_MULT      4
`define OCCS_PLL_IN_KHZ    10000
`define OCCS_PLL_OUT_KHZ   40000
`endif

//--- hdl/occs_pkg.sv
// types shared by the clock select block
package occs_pkg;
    // oscillator modes; order gives the configuration code 0..9
    typedef enum logic [3:0] {
        low_power_crystal_mode,
        std_crystal_mode,
        high_speed_crystal_mode,
        high_speed_pll_mode,
        resistor_cap_osc_mode,
        resistor_cap_io_mode,
        internal_osc_clkout_mode,
        internal_osc_dual_io_mode,
        external_clock_mode,
        external_clock_io_mode
    } occs_mode_t;
    // system clock source
    typedef enum logic [1:0] {
        src_primary,
        src_fast_direct,
        src_fast_post,
        src_slow_direct
    } occs_src_t;
endpackage

//--- hdl/occs_div4.sv
// free-running divide-by-four of the oscillator, 50% duty
`timescale 1ns/10ps
module occs_div4 (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // oscillator cycle pulse
    input  wire logic osc_tick,
    // divided clock
    output logic      clk_div4
);
    logic [1:0] cnt_q; // two-bit phase counter

    // msb of a two-bit counter is high two ticks of four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 2'h0;
        end else if (osc_tick) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    assign clk_div4 = cnt_q[1];
endmodule

//--- hdl/occs_postscale.sv
// postscaler: divides fast oscillator pulses by 2 to 64
`timescale 1ns/10ps
module occs_postscale (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // fast oscillator cycle pulse
    input  wire logic       src_tick,
    // frequency select code 1..6
    input  wire logic [2:0] fsel,
    // divided cycle pulse
    output logic            out_tick
);
    logic [5:0] cnt_q;   // pulse counter
    logic       tick_q;  // registered output pulse
    logic [5:0] last;    // terminal count for this code
    logic       wrap;

    // code 6 halves, code 1 divides by 64
    assign last = 6'((7'h01 << (3'h7 - fsel)) - 7'h01);
    assign wrap = src_tick && (cnt_q >= last);

    // a code change restarts cleanly since >= catches overshoot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 6'h00;
            tick_q <= 1'b0;
        end else begin
            tick_q <= wrap;
            if (wrap) begin
                cnt_q <= 6'h00;
            end else if (src_tick) begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end

    assign out_tick = tick_q;
endmodule

//--- test/occs_osc_model.sv
// far-side model: oscillator pulses and the levels seen on the two pins
`timescale 1ns/10ps
module occs_osc_model (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pulse spacing in pclk cycles, prompt or slow
    input  wire logic [31:0] prim_per,
    input  wire logic [31:0] fast_per,
    input  wire logic [31:0] slow_per,
    // one-cycle oscillator pulses
    output logic      prim_tick,
    output logic      fast_tick,
    output logic      slow_tick,
    // external clock level driven onto the in pin
    output logic      ext_clk_lvl,
    // released out pin: flips each cycle so no stale level survives
    output logic      out_pin_ext
);
    int pc; // primary cycle counter
    int fc; // fast cycle counter
    int sc; // slow cycle counter
    // pulses restart after reset, so the bench counts from zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc          <= 0;
            fc          <= 0;
            sc          <= 0;
            prim_tick   <= 1'b0;
            fast_tick   <= 1'b0;
            slow_tick   <= 1'b0;
            ext_clk_lvl <= 1'b0;
            out_pin_ext <= 1'b0;
        end else begin
            pc          <= (pc + 1 >= prim_per) ? 0 : pc + 1;
            fc          <= (fc + 1 >= fast_per) ? 0 : fc + 1;
            sc          <= (sc + 1 >= slow_per) ? 0 : sc + 1;
            prim_tick   <= (pc + 1 >= prim_per);
            fast_tick   <= (fc + 1 >= fast_per);
            slow_tick   <= (sc + 1 >= slow_per);
            out_pin_ext <= !out_pin_ext;
            // external clock toggles once per primary cycle
            if (pc + 1 >= prim_per) begin
                ext_clk_lvl <= !ext_clk_lvl;
            end
        end
    end
endmodule

//--- test/test_oscillator_mode_clock_select.sv
// self-checking bench for the oscillator mode clock select block
`timescale 1ns/10ps
`include "occs_defines.svh"
module test_oscillator_mode_clock_select
    import occs_pkg::*;
;
    localparam logic [31:0] Z32 = 32'h0000_0000; // idle data word
    logic             pclk = 1'b0;
    logic             presetn, psel, penable, pwrite;
    logic      [11:0] paddr;
    logic      [31:0] pwdata, prdata;
    logic             pready, pslverr;
    logic      [3:0]  osc_mode_config;
    logic             primary_osc_tick, fast_osc_tick, slow_osc_tick;
    logic             pll_enable, osc_amp_enable, startup_timer_enable;
    logic             fast_osc_enable, slow_osc_enable, sys_osc_tick;
    logic signed [5:0] osc_trim_value;
    occs_src_t        sys_clk_src;
    logic             osc_in_pin_in, osc_in_pin_out, osc_in_pin_oe;
    logic             osc_out_pin_in, osc_out_pin_out, osc_out_pin_oe;
    logic             port_a_bit6_out, port_a_bit6_oe, port_a_bit6_in;
    logic             port_a_bit7_out, port_a_bit7_oe, port_a_bit7_in;
    logic             ext_clk_lvl, out_pin_ext;
    int               prim_per, fast_per, slow_per;
    int               miscompares, cmp_count, cyc, tick_cnt;

    // 10 MHz clock
    always #50 pclk = !pclk;

    // pin levels: whoever enables drives, else the far side
    assign osc_in_pin_in  = osc_in_pin_oe ? osc_in_pin_out : ext_clk_lvl;
    assign osc_out_pin_in = osc_out_pin_oe ? osc_out_pin_out : out_pin_ext;

    occs_clock_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_mode_config(osc_mode_config),
        .primary_osc_tick(primary_osc_tick), .fast_osc_tick(fast_osc_tick),
        .slow_osc_tick(slow_osc_tick), .pll_enable(pll_enable),
        .osc_amp_enable(osc_amp_enable),
        .startup_timer_enable(startup_timer_enable),
        .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
        .osc_trim_value(osc_trim_value), .sys_clk_src(sys_clk_src),
        .sys_osc_tick(sys_osc_tick), .osc_in_pin_in(osc_in_pin_in),
        .osc_in_pin_out(osc_in_pin_out), .osc_in_pin_oe(osc_in_pin_oe),
        .osc_out_pin_in(osc_out_pin_in), .osc_out_pin_out(osc_out_pin_out),
        .osc_out_pin_oe(osc_out_pin_oe), .port_a_bit6_out(port_a_bit6_out),
        .port_a_bit6_oe(port_a_bit6_oe), .port_a_bit6_in(port_a_bit6_in),
        .port_a_bit7_out(port_a_bit7_out), .port_a_bit7_oe(port_a_bit7_oe),
        .port_a_bit7_in(port_a_bit7_in));

    occs_osc_model u_osc (.pclk(pclk), .presetn(presetn),
        .prim_per(prim_per), .fast_per(fast_per), .slow_per(slow_per),
        .prim_tick(primary_osc_tick), .fast_tick(fast_osc_tick),
        .slow_tick(slow_osc_tick), .ext_clk_lvl(ext_clk_lvl),
        .out_pin_ext(out_pin_ext));

    // system ticks since reset, the reference for the divider
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 0;
        end else if (sys_osc_tick === 1'b1) begin
            tick_cnt <= tick_cnt + 1;
        end
    end

    // hang guard, well above the few thousand cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic stop_test;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; waits for pready as long as it takes
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready ends this wait; if it never rises, only the bench's hang guard does
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // strap is only taken after a reset, so each mode needs one
    task automatic do_reset(input logic [3:0] m);
        @(posedge pclk);
        presetn         <= 1'b0;
        osc_mode_config <= m;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task automatic t_regs;
        logic [31:0] r;
        logic [31:0] st;
        logic        e;
        do_reset(4'h0);
        apb(1'b0, `OCCS_TRIM_OFS, Z32, r, e);
        chk("trim reset", Z32, r);
        chk("pready", 32'h0000_0001, pready);
        apb(1'b0, `OCCS_STAT_OFS, Z32, st, e);
        apb(1'b1, `OCCS_TRIM_OFS, 32'hFFFF_FFE0, r, e);
        apb(1'b0, `OCCS_TRIM_OFS, Z32, r, e);
        chk("trim rw", 32'h0000_0020, r);
        chk("trim value", 32'h0000_0020, {26'h0, osc_trim_value});
        apb(1'b1, `OCCS_STAT_OFS, 32'h0000_00FF, r, e);
        chk("stat write error", 32'h0000_0001, e);
        apb(1'b0, `OCCS_STAT_OFS, Z32, r, e);
        chk("stat unchanged", st, r);
        apb(1'b0, 12'h00C, Z32, r, e);
        chk("unmapped error", 32'h0000_0001, e);
        for (int b = 4; b < 8; b++) begin
            apb(1'b1, `OCCS_CTRL_OFS, 32'h0000_0001 << b, r, e);
            repeat (2) @(posedge pclk);
            chk("slow enable feature", 32'h0000_0001, slow_osc_enable);
        end
    endtask

    task automatic t_modes;
        logic [31:0] r;
        logic        e;
        logic [3:0]  m;
        logic        pll, xtal, fo4, io6, intl;
        occs_src_t   es;
        for (int i = 0; i < 11; i++) begin
            do_reset(4'(i));
            m    = (i > 9) ? 4'h0 : 4'(i);
            pll  = (m == 4'h3);
            xtal = (m <= 4'h3);
            fo4  = (m == 4'h4) || (m == 4'h6) || (m == 4'h8);
            io6  = (m == 4'h5) || (m == 4'h7) || (m == 4'h9);
            intl = (m == 4'h6) || (m == 4'h7);
            es   = intl ? src_slow_direct : src_primary;
            apb(1'b0, `OCCS_STAT_OFS, Z32, r, e);
            chk("stat", {24'h0, xtal, intl, 1'b0, pll, m}, r);
            @(negedge pclk);
            chk("pll enable", pll, pll_enable);
            chk("start-up timer", xtal, startup_timer_enable);
            chk("amp enable", xtal, osc_amp_enable);
            chk("out pin oe", fo4, osc_out_pin_oe);
            chk("bit6 in", io6 & osc_out_pin_in, port_a_bit6_in);
            chk("in pin oe", intl, osc_in_pin_oe);
            chk("bit7 in", intl, port_a_bit7_in);
            chk("clock source", es, sys_clk_src);
            if (!intl) begin
                chk("sys tick", primary_osc_tick, sys_osc_tick);
            end
        end
    endtask

    task automatic t_div4;
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            prim_per <= (k == 0) ? 4 : 7;
            do_reset((k == 0) ? 4'h8 : 4'h4);
            repeat (60) begin
                @(negedge pclk);
                chk("fosc4 out", tick_cnt[1], osc_out_pin_out);
            end
        end
    endtask

    task automatic t_internal;
        logic [31:0] r;
        logic        e;
        int          n;
        int          sel;
        occs_src_t   es;
        do_reset(4'h7);
        for (int i = 0; i < 8; i++) begin
            sel = 7 - i;
            es  = (sel == 7) ? src_fast_direct :
                  ((sel == 0) ? src_slow_direct : src_fast_post);
            apb(1'b1, `OCCS_CTRL_OFS, 32'(sel), r, e);
            repeat (256) @(posedge pclk);
            n = 0;
            repeat (256) begin
                @(negedge pclk);
                n += (sys_osc_tick === 1'b1);
            end
            chk("tick count", (sel == 0) ? 16 : 128 >> (7 - sel), n);
            chk("fast enable", sel != 0, fast_osc_enable);
            chk("slow enable", 32'h0000_0001, slow_osc_enable);
            chk("select source", es, sys_clk_src);
        end
    endtask

    initial begin
        presetn         = 1'b0;
        psel            = 1'b0;
        penable         = 1'b0;
        pwrite          = 1'b0;
        paddr           = 12'h000;
        pwdata          = Z32;
        osc_mode_config = 4'h0;
        port_a_bit6_out = 1'b1;
        port_a_bit6_oe  = 1'b0;
        port_a_bit7_out = 1'b1;
        port_a_bit7_oe  = 1'b1;
        prim_per        = 4;
        fast_per        = 2;
        slow_per        = 16;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_modes();
        t_div4();
        t_internal();
        stop_test();
    end
endmodule
